// ==== logic/frp_decoder.sv ====
// Flash protection configuration byte, its load after reset, the range check for
// program and erase targets, the violation flag and the interrupt.
// Assumes a flash read port that answers one read request with a valid strobe,
// and a command controller that presents each target address with op_valid_i.

// Contract
// RULE_01: Software leaves the spare flag bit 6 in its erased state.
// RULE_02: High disable bit 5 at zero enables the upper range, one disables it.
// RULE_03: High size bits 4..3 change only while the high disable bit is set.
// RULE_04: Low disable bit 2 at zero enables the lower range, one disables it.
// RULE_05: Low size bits 1..0 change only while the low disable bit is set.
// RULE_06: Polarity one protects enabled ranges; both disabled means nothing protected.
// RULE_07: Polarity zero protects all except enabled ranges; both disabled protects everything.
// RULE_08: High size selects 2, 4, 8 or 16 Kbytes ending at the map top.
// RULE_09: Low size selects 512 bytes to 4 Kbytes starting at the low base.
// RULE_10: Configuration loads from flash after reset, software may change it later.
// RULE_11: Polarity bit 7 selects whether enabled ranges are protected or unprotected.
// RULE_12: Polarity bit can be written only from one to zero.
// RULE_13: The load after reset reads the fixed protection byte address.
// RULE_14: Program or erase inside protection, or guarded mass erase, sets violation.
// RULE_15: Each target address gets a combinational protected indication.
module frp_decoder
	import frp_pkg::*;
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_i,
	// Register port.
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [7:0] reg_rdata_o,
	// Flash read port for the load after reset.
	output logic flash_rd_req_o,
	output logic [15:0] flash_rd_addr_o,
	input wire logic flash_rd_valid_i,
	input wire logic [7:0] flash_rd_data_i,
	// Operation check from the command controller.
	input wire logic op_valid_i,
	input wire logic [1:0] op_kind_i,
	input wire logic [15:0] op_addr_i,
	output logic op_protected_o,
	output logic op_violation_o,
	// State toward the rest of the flash module.
	output logic [7:0] config_o,
	output logic loaded_o,
	output logic irq_o
);

	logic [7:0] cfg_q;
	logic [7:0] cfg_d;
	logic [7:0] stat_q;
	logic [7:0] stat_d;
	logic [7:0] mask_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	frp_ld_t ld_q;
	frp_ld_t ld_d;
	logic addr_protected;
	logic any_prot;

	// Address decode.
	wire sel_cfg = reg_addr_i == FRP_OFS_CFG;
	wire sel_stat = reg_addr_i == FRP_OFS_STAT;
	wire sel_mask = reg_addr_i == FRP_OFS_MASK;
	wire loaded = ld_q == FRP_LD_RUN;
	// Software writes to the byte are ignored until the loaded value is in place.
	wire wr_cfg = reg_we_i && sel_cfg && loaded; // RULE_10
	wire wr_stat = reg_we_i && sel_stat;
	wire wr_mask = reg_we_i && sel_mask;
	wire load_take = (ld_q == FRP_LD_WAIT) && flash_rd_valid_i;

	// Software value of the byte after the write locks.
	// The spare bit is stored as written; keeping it erased is up to software.
	wire [7:0] cfg_sw;
	assign cfg_sw[FRP_POL_BIT] = cfg_q[FRP_POL_BIT] && reg_wdata_i[FRP_POL_BIT]; // RULE_12
	assign cfg_sw[FRP_SPARE_BIT] = reg_wdata_i[FRP_SPARE_BIT];
	assign cfg_sw[FRP_HDIS_BIT] = reg_wdata_i[FRP_HDIS_BIT];
	assign cfg_sw[FRP_HSZ_HI:FRP_HSZ_LO] = cfg_q[FRP_HDIS_BIT] ?
		reg_wdata_i[FRP_HSZ_HI:FRP_HSZ_LO] : cfg_q[FRP_HSZ_HI:FRP_HSZ_LO]; // RULE_03
	assign cfg_sw[FRP_LDIS_BIT] = reg_wdata_i[FRP_LDIS_BIT];
	assign cfg_sw[FRP_LSZ_HI:FRP_LSZ_LO] = cfg_q[FRP_LDIS_BIT] ?
		reg_wdata_i[FRP_LSZ_HI:FRP_LSZ_LO] : cfg_q[FRP_LSZ_HI:FRP_LSZ_LO]; // RULE_05

	// The flash image is taken whole, without the software write locks.
	assign cfg_d = load_take ? flash_rd_data_i : (wr_cfg ? cfg_sw : cfg_q); // RULE_10

	// Load sequencer: one read of the protection byte, then normal operation.
	always_comb
	begin
		ld_d = ld_q;
		unique case (ld_q)
			FRP_LD_REQ: ld_d = FRP_LD_WAIT;
			FRP_LD_WAIT: ld_d = flash_rd_valid_i ? FRP_LD_RUN : FRP_LD_WAIT;
			FRP_LD_RUN: ld_d = FRP_LD_RUN;
			default: ld_d = FRP_LD_REQ;
		endcase
	end

	assign flash_rd_req_o = ld_q == FRP_LD_REQ;
	assign flash_rd_addr_o = FRP_PROT_BYTE_ADDR; // RULE_13

	// Range check of the presented target.
	frp_range_check u_range
	(
		.cfg_i(cfg_q),
		.loaded_i(loaded),
		.addr_i(op_addr_i),
		.protected_o(addr_protected),
		.any_prot_o(any_prot)
	);

	wire is_mass = op_kind_i == FRP_OP_MASS_ERASE;
	wire is_addr_op = (op_kind_i == FRP_OP_PROGRAM) || (op_kind_i == FRP_OP_SECTOR_ERASE);
	// Mass erase needs protection fully off, whatever the address says.
	assign op_protected_o = is_mass ? any_prot : addr_protected; // RULE_15
	assign op_violation_o = op_valid_i &&
		((is_addr_op && addr_protected) || (is_mass && any_prot)); // RULE_14

	// Sticky status: a new event wins over a write-one-to-clear in the same cycle.
	wire [7:0] stat_set = {6'h00, load_take, op_violation_o};
	wire [7:0] stat_clr = wr_stat ? reg_wdata_i : 8'h00;
	assign stat_d = ((stat_q & ~stat_clr) | stat_set) & FRP_ST_IMPL; // RULE_14

	// Read data stand in the cycle after the read strobe; unmapped offsets read zero.
	assign rdata_d = !reg_re_i ? FRP_RDATA_RST :
		sel_cfg ? cfg_q :
		sel_stat ? stat_q :
		sel_mask ? mask_q : 8'h00;

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			ld_q <= FRP_LD_REQ;
			cfg_q <= FRP_CFG_RST;
			stat_q <= FRP_STAT_RST;
			mask_q <= FRP_MASK_RST;
			rdata_q <= FRP_RDATA_RST;
		end
		else
		begin
			ld_q <= ld_d;
			cfg_q <= cfg_d;
			stat_q <= stat_d;
			if (wr_mask)
				mask_q <= reg_wdata_i & FRP_ST_IMPL;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign config_o = cfg_q;
	assign loaded_o = loaded;
	assign irq_o = |(stat_q & mask_q);

	// Checks.
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	property p_pol_no_rise;
		$past(loaded) |-> !$rose(cfg_q[FRP_POL_BIT]);
	endproperty
	a_pol_no_rise: assert property (p_pol_no_rise) // RULE_12
		else $error("Polarity bit rose after the load.");

	property p_hsz_lock;
		(wr_cfg && !cfg_q[FRP_HDIS_BIT]) |=> $stable(cfg_q[FRP_HSZ_HI:FRP_HSZ_LO]);
	endproperty
	a_hsz_lock: assert property (p_hsz_lock) // RULE_03
		else $error("High size changed while the high range was enabled.");

	property p_lsz_lock;
		(wr_cfg && !cfg_q[FRP_LDIS_BIT]) |=> $stable(cfg_q[FRP_LSZ_HI:FRP_LSZ_LO]);
	endproperty
	a_lsz_lock: assert property (p_lsz_lock) // RULE_05
		else $error("Low size changed while the low range was enabled.");

	property p_hsz_open;
		(wr_cfg && cfg_q[FRP_HDIS_BIT])
			|=> cfg_q[FRP_HSZ_HI:FRP_HSZ_LO] == $past(reg_wdata_i[FRP_HSZ_HI:FRP_HSZ_LO]);
	endproperty
	a_hsz_open: assert property (p_hsz_open) // RULE_03
		else $error("High size write lost while the high range was disabled.");

	property p_none_prot;
		(loaded && cfg_q[FRP_POL_BIT] && cfg_q[FRP_HDIS_BIT] && cfg_q[FRP_LDIS_BIT])
			|-> !addr_protected && !any_prot;
	endproperty
	a_none_prot: assert property (p_none_prot) // RULE_06
		else $error("Address protected with protection fully off.");

	property p_full_prot;
		(!cfg_q[FRP_POL_BIT] && cfg_q[FRP_HDIS_BIT] && cfg_q[FRP_LDIS_BIT]) |-> addr_protected;
	endproperty
	a_full_prot: assert property (p_full_prot) // RULE_07
		else $error("Address left open with the whole array protected.");

	property p_high_edge;
		(loaded && cfg_q[FRP_POL_BIT] && !cfg_q[FRP_HDIS_BIT] && cfg_q[FRP_LDIS_BIT]
			&& cfg_q[FRP_HSZ_HI:FRP_HSZ_LO] == 2'h0)
			|-> addr_protected == (op_addr_i >= FRP_HIGH_BASE_00);
	endproperty
	a_high_edge: assert property (p_high_edge) // RULE_08
		else $error("Smallest high range boundary wrong.");

	property p_low_edge;
		(loaded && cfg_q[FRP_POL_BIT] && cfg_q[FRP_HDIS_BIT] && !cfg_q[FRP_LDIS_BIT]
			&& cfg_q[FRP_LSZ_HI:FRP_LSZ_LO] == 2'h3)
			|-> addr_protected == (op_addr_i >= FRP_LOW_BASE && op_addr_i <= FRP_LOW_END_11);
	endproperty
	a_low_edge: assert property (p_low_edge) // RULE_09
		else $error("Largest low range boundary wrong.");

	property p_viol_sets;
		(op_valid_i && is_addr_op && op_protected_o) |=> stat_q[FRP_ST_VIOL_BIT];
	endproperty
	a_viol_sets: assert property (p_viol_sets) // RULE_14
		else $error("Violation flag not set by a protected target.");

	property p_mass_viol;
		(op_valid_i && is_mass && any_prot)
			|=> stat_q[FRP_ST_VIOL_BIT] && (irq_o || !mask_q[FRP_ST_VIOL_BIT]);
	endproperty
	a_mass_viol: assert property (p_mass_viol) // RULE_14
		else $error("Guarded mass erase did not set the violation flag.");

	property p_load_addr;
		flash_rd_req_o |-> flash_rd_addr_o == FRP_PROT_BYTE_ADDR ##1 !flash_rd_req_o;
	endproperty
	a_load_addr: assert property (p_load_addr) // RULE_13
		else $error("Load request malformed.");

	property p_load_take;
		load_take |=> loaded && cfg_q == $past(flash_rd_data_i);
	endproperty
	a_load_take: assert property (p_load_take) // RULE_10
		else $error("Loaded byte not taken from the flash read.");

	property p_lsz_open;
		(wr_cfg && cfg_q[FRP_LDIS_BIT])
			|=> cfg_q[FRP_LSZ_HI:FRP_LSZ_LO] == $past(reg_wdata_i[FRP_LSZ_HI:FRP_LSZ_LO]);
	endproperty
	a_lsz_open: assert property (p_lsz_open) // RULE_05
		else $error("Low size write lost while the low range was disabled.");

	property p_hdis_free;
		wr_cfg |=> cfg_q[FRP_HDIS_BIT] == $past(reg_wdata_i[FRP_HDIS_BIT]);
	endproperty
	a_hdis_free: assert property (p_hdis_free) // RULE_02
		else $error("High disable bit did not take the written value.");

	property p_ldis_free;
		wr_cfg |=> cfg_q[FRP_LDIS_BIT] == $past(reg_wdata_i[FRP_LDIS_BIT]);
	endproperty
	a_ldis_free: assert property (p_ldis_free) // RULE_04
		else $error("Low disable bit did not take the written value.");

	property p_pol_clear;
		(wr_cfg && !reg_wdata_i[FRP_POL_BIT]) |=> !cfg_q[FRP_POL_BIT];
	endproperty
	a_pol_clear: assert property (p_pol_clear) // RULE_12
		else $error("Polarity bit not cleared by a zero write.");

	property p_high_top;
		(loaded && cfg_q[FRP_POL_BIT] && !cfg_q[FRP_HDIS_BIT] && op_addr_i == FRP_HIGH_END)
			|-> addr_protected;
	endproperty
	a_high_top: assert property (p_high_top) // RULE_02
		else $error("Top of the map open with the high range enabled.");

	property p_low_base;
		(loaded && cfg_q[FRP_POL_BIT] && !cfg_q[FRP_LDIS_BIT] && op_addr_i == FRP_LOW_BASE)
			|-> addr_protected;
	endproperty
	a_low_base: assert property (p_low_base) // RULE_04
		else $error("Low base open with the low range enabled.");

	// Until the byte is in place no software write may move it.
	property p_preload_cfg;
		(!loaded && !load_take) |=> $stable(cfg_q);
	endproperty
	a_preload_cfg: assert property (p_preload_cfg) // RULE_10
		else $error("Configuration changed before the load.");

	property p_preload_prot;
		!loaded |-> addr_protected && any_prot;
	endproperty
	a_preload_prot: assert property (p_preload_prot) // RULE_10
		else $error("Something left open before the load.");

	property p_loaded_stays;
		loaded |=> loaded && !flash_rd_req_o;
	endproperty
	a_loaded_stays: assert property (p_loaded_stays) // RULE_13
		else $error("Load repeated or lost without a reset.");

	property p_kind_none;
		(op_kind_i == FRP_OP_NONE) |-> !op_violation_o;
	endproperty
	a_kind_none: assert property (p_kind_none) // RULE_14
		else $error("Violation raised with no operation.");

	property p_viol_cause;
		op_violation_o |-> op_valid_i && op_protected_o;
	endproperty
	a_viol_cause: assert property (p_viol_cause) // RULE_15
		else $error("Violation raised for an unprotected target.");

	property p_set_wins;
		(op_violation_o && wr_stat && reg_wdata_i[FRP_ST_VIOL_BIT])
			|=> stat_q[FRP_ST_VIOL_BIT];
	endproperty
	a_set_wins: assert property (p_set_wins) // RULE_14
		else $error("Clear won over a new violation.");

	property p_viol_w1c;
		(wr_stat && reg_wdata_i[FRP_ST_VIOL_BIT] && !op_violation_o)
			|=> !stat_q[FRP_ST_VIOL_BIT];
	endproperty
	a_viol_w1c: assert property (p_viol_w1c) // RULE_14
		else $error("Violation flag not cleared by a one write.");

	property p_viol_sticky;
		(stat_q[FRP_ST_VIOL_BIT] && !(wr_stat && reg_wdata_i[FRP_ST_VIOL_BIT]))
			|=> stat_q[FRP_ST_VIOL_BIT];
	endproperty
	a_viol_sticky: assert property (p_viol_sticky) // RULE_14
		else $error("Violation flag dropped without a clear.");

	property p_irq_viol;
		(stat_q[FRP_ST_VIOL_BIT] && mask_q[FRP_ST_VIOL_BIT]) |-> irq_o;
	endproperty
	a_irq_viol: assert property (p_irq_viol) // RULE_14
		else $error("Unmasked violation without an interrupt.");

	property p_cfg_read;
		($past(reg_re_i) && $past(sel_cfg)) |-> reg_rdata_o == $past(cfg_q);
	endproperty
	a_cfg_read: assert property (p_cfg_read) // RULE_10
		else $error("Configuration read returned a wrong byte.");

	property p_rdata_idle;
		!$past(reg_re_i) |-> reg_rdata_o == FRP_RDATA_RST;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) // RULE_10
		else $error("Read data stood longer than one cycle.");

	c_load: cover property (flash_rd_req_o ##[1:20] loaded);
	c_viol_clear: cover property (op_violation_o ##1 wr_stat && reg_wdata_i[FRP_ST_VIOL_BIT]);
	c_pol_clear: cover property (wr_cfg && cfg_q[FRP_POL_BIT] && !reg_wdata_i[FRP_POL_BIT]);
	c_irq: cover property ($rose(irq_o));
	c_full_prot: cover property (loaded && !cfg_q[FRP_POL_BIT] && addr_protected);

endmodule

// ==== common/frp_pkg.sv ====
// Constants shared by the flash range protection decoder and its range checker.
// Assumes a 16-bit flash address map and an 8-bit register port.
package frp_pkg;

	// Register offsets on the register port.
	localparam logic [7:0] FRP_OFS_CFG = 8'h04;
	localparam logic [7:0] FRP_OFS_STAT = 8'h05;
	localparam logic [7:0] FRP_OFS_MASK = 8'h06;

	// Field positions of the protection configuration byte.
	localparam int FRP_POL_BIT = 7;
	localparam int FRP_SPARE_BIT = 6;
	localparam int FRP_HDIS_BIT = 5;
	localparam int FRP_HSZ_HI = 4;
	localparam int FRP_HSZ_LO = 3;
	localparam int FRP_LDIS_BIT = 2;
	localparam int FRP_LSZ_HI = 1;
	localparam int FRP_LSZ_LO = 0;

	// Status and mask bit positions.
	localparam int FRP_ST_VIOL_BIT = 0;
	localparam int FRP_ST_LOAD_BIT = 1;
	localparam logic [7:0] FRP_ST_IMPL = 8'h03;

	// Reset values.
	localparam logic [7:0] FRP_CFG_RST = 8'hFF;
	localparam logic [7:0] FRP_STAT_RST = 8'h00;
	localparam logic [7:0] FRP_MASK_RST = 8'h00;
	localparam logic [7:0] FRP_RDATA_RST = 8'h00;

	// Flash location of the protection byte loaded after reset.
	localparam logic [15:0] FRP_PROT_BYTE_ADDR = 16'hFF0D;

	// Range limits.
	localparam logic [15:0] FRP_HIGH_BASE_00 = 16'hF800;
	localparam logic [15:0] FRP_HIGH_BASE_01 = 16'hF000;
	localparam logic [15:0] FRP_HIGH_BASE_10 = 16'hE000;
	localparam logic [15:0] FRP_HIGH_BASE_11 = 16'hC000;
	localparam logic [15:0] FRP_HIGH_END = 16'hFFFF;
	localparam logic [15:0] FRP_LOW_BASE = 16'h4000;
	localparam logic [15:0] FRP_LOW_END_00 = 16'h41FF;
	localparam logic [15:0] FRP_LOW_END_01 = 16'h43FF;
	localparam logic [15:0] FRP_LOW_END_10 = 16'h47FF;
	localparam logic [15:0] FRP_LOW_END_11 = 16'h4FFF;

	// Kinds of operation checked against the protection.
	typedef enum logic [1:0] {
		FRP_OP_PROGRAM = 2'b00,
		FRP_OP_SECTOR_ERASE = 2'b01,
		FRP_OP_MASS_ERASE = 2'b10,
		FRP_OP_NONE = 2'b11
	} frp_op_t;

	// Load sequencer states.
	typedef enum logic [1:0] {
		FRP_LD_REQ = 2'b00,
		FRP_LD_WAIT = 2'b01,
		FRP_LD_RUN = 2'b10
	} frp_ld_t;

endpackage

// ==== logic/frp_range_check.sv ====
// Combinational check of one flash address against the decoded ranges.
// Assumes the configuration byte is stable and already loaded when loaded_i is high.
module frp_range_check
	import frp_pkg::*;
(
	// Configuration.
	input wire logic [7:0] cfg_i,
	input wire logic loaded_i,
	// Address under test.
	input wire logic [15:0] addr_i,
	// Results.
	output logic protected_o,
	output logic any_prot_o
);

	logic [15:0] high_base;
	logic [15:0] low_end;
	wire pol = cfg_i[FRP_POL_BIT];
	wire hdis = cfg_i[FRP_HDIS_BIT];
	wire ldis = cfg_i[FRP_LDIS_BIT];
	wire [1:0] hsz = cfg_i[FRP_HSZ_HI:FRP_HSZ_LO];
	wire [1:0] lsz = cfg_i[FRP_LSZ_HI:FRP_LSZ_LO];

	// Each high range ends at the top of the map.
	assign high_base = (hsz == 2'h0) ? FRP_HIGH_BASE_00 :
		(hsz == 2'h1) ? FRP_HIGH_BASE_01 :
		(hsz == 2'h2) ? FRP_HIGH_BASE_10 : FRP_HIGH_BASE_11; // RULE_08
	// Each low range starts at the same base.
	assign low_end = (lsz == 2'h0) ? FRP_LOW_END_00 :
		(lsz == 2'h1) ? FRP_LOW_END_01 :
		(lsz == 2'h2) ? FRP_LOW_END_10 : FRP_LOW_END_11; // RULE_09

	wire in_high = (addr_i >= high_base) && (addr_i <= FRP_HIGH_END);
	wire in_low = (addr_i >= FRP_LOW_BASE) && (addr_i <= low_end);
	// A disable bit at zero enables its range.
	wire hit_high = !hdis && in_high; // RULE_02
	wire hit_low = !ldis && in_low; // RULE_04
	wire hit = hit_high || hit_low;

	// Polarity swaps the meaning of the enabled ranges; before the load everything is protected.
	assign protected_o = !loaded_i || (pol ? hit : !hit); // RULE_06 RULE_07 RULE_11 RULE_15
	assign any_prot_o = !loaded_i || !(pol && hdis && ldis); // RULE_14

endmodule

// ==== verification/frp_flash_model.sv ====
// Behavioural flash read port that answers the protection byte load.
// Assumes one request per reset; the answer comes DELAY plus one cycles after the request cycle.
module frp_flash_model
	import frp_pkg::*;
#(
	parameter logic [7:0] IMAGE = 8'hFF,
	parameter int DELAY = 3
)
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_i,
	// Read port.
	input wire logic rd_req_i,
	input wire logic [15:0] rd_addr_i,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o
);
	int cnt_q;
	logic [15:0] addr_q;

	// Data toggles outside the answer so a stale byte is never mistaken for a load.
	always_ff @(posedge clock_i)
	begin
		rd_valid_o <= 1'b0;
		rd_data_o <= ~rd_data_o;
		if (rst_i)
		begin
			cnt_q <= 0;
			rd_data_o <= 8'hA5;
		end
		else if (rd_req_i)
		begin
			cnt_q <= DELAY;
			addr_q <= rd_addr_i;
		end
		else if (cnt_q != 0)
			cnt_q <= cnt_q - 1;
		if (!rst_i && cnt_q == 1)
		begin
			rd_valid_o <= 1'b1;
			rd_data_o <= (addr_q == FRP_PROT_BYTE_ADDR) ? IMAGE : 8'h00;
		end
	end
endmodule

// ==== verification/frp_decoder_tb.sv ====
// Self-checking bench for the flash protection decoder.
// Assumes the flash model holds an image with the spare bit erased.
module frp_decoder_tb
	import frp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_we_i = 1'b0;
	logic reg_re_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic flash_rd_req_o;
	logic [15:0] flash_rd_addr_o;
	logic flash_rd_valid_i;
	logic [7:0] flash_rd_data_i;
	logic op_valid_i = 1'b0;
	logic [1:0] op_kind_i = 2'b00;
	logic [15:0] op_addr_i = 16'h0000;
	logic op_protected_o;
	logic op_violation_o;
	logic [7:0] config_o;
	logic loaded_o;
	logic irq_o;
	int miscompares = 0;
	int checks_done = 0;
	logic [15:0] hi_base [4] = '{FRP_HIGH_BASE_00, FRP_HIGH_BASE_01,
		FRP_HIGH_BASE_10, FRP_HIGH_BASE_11};
	logic [15:0] lo_end [4] = '{FRP_LOW_END_00, FRP_LOW_END_01,
		FRP_LOW_END_10, FRP_LOW_END_11};

	always #2.5 clock_i = ~clock_i;

	frp_decoder u_frp_decoder (.clock_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
		.reg_re_i, .reg_rdata_o, .flash_rd_req_o, .flash_rd_addr_o, .flash_rd_valid_i,
		.flash_rd_data_i, .op_valid_i, .op_kind_i, .op_addr_i, .op_protected_o,
		.op_violation_o, .config_o, .loaded_o, .irq_o);

	// The image differs from the reset value so that a missing load shows.
	frp_flash_model #(.IMAGE(8'hE5)) u_frp_flash_model (.clock_i(clock_i), .rst_i(rst_i),
		.rd_req_i(flash_rd_req_o), .rd_addr_i(flash_rd_addr_o),
		.rd_valid_o(flash_rd_valid_i), .rd_data_o(flash_rd_data_i));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clock_i);
		reg_we_i <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clock_i);
		reg_re_i <= 1'b0;
		// The read data stand only in the cycle after the strobe, so look mid-cycle.
		@(negedge clock_i);
		chk(16'(reg_rdata_o), 16'(e));
		@(posedge clock_i);
	endtask

	task automatic pr(input logic [15:0] a, input logic e);
		op_addr_i <= a;
		@(posedge clock_i);
		chk(16'(op_protected_o), 16'(e));
	endtask

	task automatic t_load();
		@(negedge clock_i);
		chk(16'(flash_rd_req_o), 16'h0001);
		chk(16'(op_protected_o), 16'h0001);
		chk(flash_rd_addr_o, FRP_PROT_BYTE_ADDR);
		@(posedge clock_i);
		wr(FRP_OFS_CFG, 8'h00);
		chk(16'(flash_rd_req_o), 16'h0000);
		chk(16'(config_o), 16'h00FF);
		for (int i = 0; i < 20 && loaded_o !== 1'b1; i++)
			@(posedge clock_i);
		chk(16'(loaded_o), 16'h0001);
		chk(16'(config_o), 16'h00E5);
		rc(FRP_OFS_STAT, 8'h02);
		rc(8'h07, 8'h00);
	endtask

	task automatic t_regs();
		wr(FRP_OFS_MASK, 8'h02);
		rc(FRP_OFS_MASK, 8'h02);
		@(negedge clock_i);
		chk(16'(reg_rdata_o), 16'h0000);
		@(posedge clock_i);
		chk(16'(irq_o), 16'h0001);
		wr(FRP_OFS_STAT, 8'h02);
		chk(16'(irq_o), 16'h0000);
		op_kind_i <= FRP_OP_MASS_ERASE;
		op_valid_i <= 1'b1;
		@(posedge clock_i);
		chk(16'(op_violation_o), 16'h0000);
		op_valid_i <= 1'b0;
		op_kind_i <= FRP_OP_PROGRAM;
	endtask

	task automatic t_ranges();
		logic [7:0] c;
		for (int s = 0; s < 4; s++)
		begin
			c = {3'b111, 2'(s), 1'b1, 2'(s)};
			wr(FRP_OFS_CFG, 8'hFF);
			wr(FRP_OFS_CFG, c);
			chk(16'(config_o), 16'(c));
			wr(FRP_OFS_CFG, c & 8'hDB);
			pr(hi_base[s] - 16'h0001, 1'b0);
			pr(hi_base[s], 1'b1);
			pr(FRP_HIGH_END, 1'b1);
			pr(FRP_LOW_BASE - 16'h0001, 1'b0);
			pr(FRP_LOW_BASE, 1'b1);
			pr(lo_end[s], 1'b1);
			pr(lo_end[s] + 16'h0001, 1'b0);
		end
		wr(FRP_OFS_CFG, 8'hC0);
		chk(16'(config_o), 16'h00DB);
		wr(FRP_OFS_CFG, 8'hFF);
		pr(FRP_HIGH_END, 1'b0);
		wr(FRP_OFS_CFG, 8'hC7);
		pr(FRP_LOW_BASE, 1'b0);
		pr(16'hF800, 1'b1);
		pr(16'hF7FF, 1'b0);
		wr(FRP_OFS_CFG, 8'hFB);
		chk(16'(config_o), 16'h00E3);
		pr(16'h4FFF, 1'b1);
		pr(16'h5000, 1'b0);
	endtask

	task automatic t_polarity();
		wr(FRP_OFS_CFG, 8'h7F);
		chk(16'(config_o), 16'h007F);
		pr(16'h0000, 1'b1);
		wr(FRP_OFS_CFG, 8'h5B);
		pr(16'hC000, 1'b0);
		pr(16'h8000, 1'b1);
		pr(16'h4FFF, 1'b0);
		wr(FRP_OFS_CFG, 8'hFF);
		chk(16'(config_o), 16'h007F);
		rc(FRP_OFS_CFG, 8'h7F);
	endtask

	task automatic t_viol();
		wr(FRP_OFS_MASK, 8'h01);
		op_addr_i <= 16'h8000;
		for (int k = 0; k < 4; k++)
		begin
			op_kind_i <= 2'(k);
			op_valid_i <= 1'b1;
			@(posedge clock_i);
			chk(16'(op_violation_o), 16'(k != 3));
		end
		op_valid_i <= 1'b0;
		@(posedge clock_i);
		chk(16'(irq_o), 16'h0001);
		rc(FRP_OFS_STAT, 8'h01);
		wr(FRP_OFS_STAT, 8'h01);
		chk(16'(irq_o), 16'h0000);
	endtask

	task automatic results();
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// The whole sequence needs well under a thousand cycles.
	initial
	begin
		repeat (3000) @(posedge clock_i);
		miscompares++;
		results();
	end

	initial
	begin
		repeat (4) @(posedge clock_i);
		rst_i <= 1'b0;
		t_load();
		t_regs();
		t_ranges();
		t_polarity();
		t_viol();
		results();
	end
endmodule
